// ==== core/cesr_core.sv ====
// Exception state register set: pointer, fault address, timer, status and cause
// Function
// RL1 - Miss loads page pair from address 31:13
// RL2 - Address faults load faulting address register
// RL3 - No fault address update at exception level
// RL4 - Bus errors leave fault address alone
// RL5 - Counter ticks every second cycle, read/write
// RL6 - Count equals compare sets timer pending
// RL7 - Compare write clears timer pending
// RL8 - Mask bits gate software and external sources
// RL9 - Interrupt needs enable, no levels, mask&pending
// RL10 - Setting enable takes effect up to 3 late
// RL11 - Usable field gates coprocessors; kernel has 0
// RL12 - Reset endian, user flip inverts it
// RL13 - Privilege field and levels decode mode
// RL14 - Extended bits select 64-bit addressing, refill vector; here kernel mode is always 64-bit and KX only picks the vector
// RL15 - Address space access follows mode
// RL16 - Reset sets error level and boot vector
// RL17 - Soft reset or NMI sets flag; only soft_reset_evt sets it here, there is no NMI input
// RL18 - Boot vector bit selects vector locations
// RL19 - Cache hit flag records last hit op
// RL20 - Only software pending bits writable in cause
// RL21 - Exception writes five-bit cause code
// RL22 - Delay slot flag and coprocessor number recorded
// RL23 - Cause codes follow fixed encoding
// RL24 - Match checked on tick and compare write
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
module cesr_core
    import cesr_pkg::*;
#(
    parameter int CNT_W = 32    // Tick counter width
)(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pipeline events
    input  wire logic        exc_valid,
    input  wire logic [4:0]  exc_code,
    input  wire logic [63:0] exc_vaddr,
    input  wire logic        exc_in_delay,
    input  wire logic [1:0]  exc_cop_unit,
    input  wire logic        exc_return,
    input  wire logic        soft_reset_evt,
    input  wire logic        cache_hit_op,
    input  wire logic        cache_hit_result,
    input  wire logic        big_endian_strap,
    input  wire logic [5:0]  ext_irq,
    // Coprocessor and address checks
    input  wire logic [1:0]  cop_req_unit,
    input  wire logic [1:0]  addr_space,
    // Status to the pipeline
    output logic             irq_take,
    output logic             kernel_mode,
    output logic             super_mode,
    output logic             user_mode,
    output logic             addr64,
    output logic             xtlb_vector,
    output logic             boot_vectors,
    output logic             big_endian_eff,
    output logic             cop_unusable,
    output logic             space_denied
);
    cesr_exc_if ev ();

    // Register contents
    logic [31:0]       status;        // Processor status
    logic [4:0]        cause_code;    // Exception cause code
    logic              cause_bd;      // Delay slot flag
    logic [1:0]        cause_ce;      // Coprocessor unit number
    logic [1:0]        sw_pend;       // Software pending bits
    logic              timer_pend;    // Timer pending bit
    logic [63:0]       fault_va;      // Faulting virtual address
    logic [VPN_W-1:0]  vpn_field;     // Missed page pair field
    logic [63:0]       ctx_base;      // Writable base part of pointer
    logic [CNT_W-1:0]  tick;          // Tick counter
    logic [CNT_W-1:0]  compare;       // Timer compare
    logic              tick_en;       // Half-rate enable
    logic              endian_strap;  // Endian caught after reset release
    logic              strap_done;    // Strap captured
    logic [IE_DELAY-1:0] ie_pipe;     // Enable settle pipeline
    logic              ie_eff;        // Enable as seen by interrupt logic

    // Bus decode
    logic        wr_acc;
    logic [9:0]  idx;
    logic [7:0]  pending;
    logic [63:0] ctx_full;

    assign wr_acc  = psel && penable && pwrite;
    assign idx     = paddr[11:2];
    assign pready  = 1'b1;    // Zero wait states
    assign pending = {timer_pend | ext_irq[5], ext_irq[4:0], sw_pend};   // see RL8, see RL6
    assign ctx_full = {ctx_base[63:VPN_LSB+VPN_W], vpn_field, {VPN_LSB{1'b0}}};

    // Unmapped indices answer with an error
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            case (idx)
                {2'h0, REG_CONTEXT_IDX}, {2'h0, REG_FAULTVA_IDX}, {2'h0, REG_TICK_IDX},
                {2'h0, REG_COMPARE_IDX}, {2'h0, REG_STATUS_IDX}, {2'h0, REG_CAUSE_IDX},
                {2'h0, REG_CONTEXT_HI},  {2'h0, REG_FAULTVA_HI}: pslverr = 1'b0;
                default:                                         pslverr = 1'b1;
            endcase
        end
    end

    // Read data is registered at setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr[11:2])
                {2'h0, REG_CONTEXT_IDX}: prdata <= ctx_full[31:0];
                {2'h0, REG_CONTEXT_HI}:  prdata <= ctx_full[63:32];
                {2'h0, REG_FAULTVA_IDX}: prdata <= fault_va[31:0];
                {2'h0, REG_FAULTVA_HI}:  prdata <= fault_va[63:32];
                {2'h0, REG_TICK_IDX}:    prdata <= tick;                      // see RL5
                {2'h0, REG_COMPARE_IDX}: prdata <= compare;                   // see RL7
                {2'h0, REG_STATUS_IDX}:  prdata <= status;
                {2'h0, REG_CAUSE_IDX}:   prdata <= {cause_bd, 1'b0, cause_ce, 12'h000, pending,
                                                    1'b0, cause_code, 2'h0};
                default:                 prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Half-rate tick enable, free running regardless of pipeline
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tick_en <= 1'b0;
        else          tick_en <= !tick_en;    // see RL5
    end

    // Tick counter; software write wins over increment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= '0;
        end else if (wr_acc && idx == {2'h0, REG_TICK_IDX}) begin
            tick <= pwdata[CNT_W-1:0];
        end else if (tick_en) begin
            tick <= tick + 1'b1;   // see RL5
        end
    end

    // Compare only changes on a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                                         compare <= '1;
        else if (wr_acc && idx == {2'h0, REG_COMPARE_IDX})    compare <= pwdata[CNT_W-1:0];  // see RL6
    end

    // Match evaluated after a tick or compare write, so it fires once per event
    logic match_chk;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) match_chk <= 1'b0;
        else          match_chk <= tick_en || (wr_acc && idx == {2'h0, REG_COMPARE_IDX}); // see RL24
    end

    // Timer pending: set wins over the clearing compare write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                                         timer_pend <= 1'b0;
        else if (match_chk && tick == compare)                timer_pend <= 1'b1;  // see RL6
        else if (wr_acc && idx == {2'h0, REG_COMPARE_IDX})    timer_pend <= 1'b0;  // see RL7
    end

    // Software pending bits are the only writable cause bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                                      sw_pend <= 2'h0;
        else if (wr_acc && idx == {2'h0, REG_CAUSE_IDX})   sw_pend <= pwdata[CA_IP +: 2];  // see RL20
    end

    // Cause record on each exception
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_code <= EXC_INT;
            cause_bd   <= 1'b0;
            cause_ce   <= 2'h0;
        end else if (exc_valid) begin
            cause_code <= exc_code;           // see RL21, see RL23
            cause_bd   <= exc_in_delay;       // see RL22
            if (exc_code == EXC_CPU)
                cause_ce <= exc_cop_unit;     // see RL22
        end
    end

    // Address capture decisions
    cesr_fault_rec u_rec (
        .exc_valid (exc_valid),
        .exc_code  (exc_code),
        .exc_vaddr (exc_vaddr),
        .exl_now   (status[ST_EXL]),
        .ev        (ev.rec)
    );

    // Faulting address capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)         fault_va <= 64'h0;
        else if (ev.load_fva) fault_va <= ev.vaddr;   // see RL2
    end

    // Page pair field from hardware; base from software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)         vpn_field <= '0;
        else if (ev.load_vpn) vpn_field <= ev.vaddr[31:13];   // see RL1
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                                       ctx_base <= 64'h0;
        else if (wr_acc && idx == {2'h0, REG_CONTEXT_IDX})  ctx_base[31:0]  <= pwdata;
        else if (wr_acc && idx == {2'h0, REG_CONTEXT_HI})   ctx_base[63:32] <= pwdata;
    end

    // Status: write, exception entry and return, hardware flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= STATUS_RESET;   // see RL16
        end else begin
            if (wr_acc && idx == {2'h0, REG_STATUS_IDX})
                status <= pwdata & STATUS_WMASK;
            if (exc_valid)
                status[ST_EXL] <= 1'b1;
            else if (exc_return)
                status[ST_EXL] <= 1'b0;
            if (soft_reset_evt) begin
                status[ST_SR]  <= 1'b1;   // see RL17
                status[ST_ERL] <= 1'b1;
                status[ST_BEV] <= 1'b1;
            end
            if (cache_hit_op)
                status[ST_CH] <= cache_hit_result;   // see RL19
        end
    end

    // Endian strap caught by a clocked process after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            endian_strap <= 1'b0;
            strap_done   <= 1'b0;
        end else if (!strap_done) begin
            endian_strap <= big_endian_strap;   // see RL12
            strap_done   <= 1'b1;
        end
    end

    // Enable rises after the settle delay, falls at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ie_pipe <= '0;
        else          ie_pipe <= {ie_pipe[IE_DELAY-2:0], status[ST_IE]};   // see RL10
    end
    assign ie_eff = status[ST_IE] && ie_pipe[IE_DELAY-1];

    // Mode decode
    logic [1:0] privilege_mode_field;
    logic       lvl_clear;
    assign privilege_mode_field        = status[ST_KSU +: 2];
    assign lvl_clear  = !status[ST_EXL] && !status[ST_ERL];
    assign user_mode  = lvl_clear && privilege_mode_field == KSU_USER;    // see RL13
    assign super_mode = lvl_clear && privilege_mode_field == KSU_SUPER;   // see RL13
    assign kernel_mode = !user_mode && !super_mode;      // see RL13

    // Interrupt request
    assign irq_take = ie_eff && lvl_clear &&
                      |(pending & status[ST_IM +: 8]);   // see RL9, see RL8

    // Addressing width and refill vector
    assign addr64 = kernel_mode ? 1'b1 :
                    super_mode  ? status[ST_SX] : status[ST_UX];   // see RL14
    assign xtlb_vector    = status[ST_KX];                         // see RL14
    assign boot_vectors   = status[ST_BEV];                        // see RL18
    assign big_endian_eff = endian_strap ^ (user_mode && status[ST_RE]);   // see RL12

    // Coprocessor usability: unit 0 always in kernel
    assign cop_unusable = !(status[ST_CU + cop_req_unit] ||
                            (cop_req_unit == 2'h0 && kernel_mode));        // see RL11

    // Space check: 0 user, 1 supervisor, 2/3 kernel
    assign space_denied = (addr_space[1] && !kernel_mode) ||
                          (addr_space == 2'h1 && user_mode);               // see RL15

    // Assertion helpers
    logic [63:0] fva_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) fva_prev <= 64'h0;
        else          fva_prev <= fault_va;
    end

    sequence s_cmp_write;
        wr_acc && idx == {2'h0, REG_COMPARE_IDX};
    endsequence

    a_fva_bus_err: assert property (@(posedge pclk) disable iff (!presetn)   // see RL4
        exc_valid && (exc_code == EXC_IBE || exc_code == EXC_DBE) |=> fault_va == $past(fault_va))
        else $error("fault address changed on bus error");
    a_fva_exl_hold: assert property (@(posedge pclk) disable iff (!presetn)  // see RL3
        exc_valid && status[ST_EXL] |=> fault_va == fva_prev)
        else $error("fault address changed at exception level");
    a_fva_load: assert property (@(posedge pclk) disable iff (!presetn)      // see RL2
        exc_valid && !status[ST_EXL] && exc_code == EXC_ADEL |=> fault_va == $past(exc_vaddr))
        else $error("fault address not loaded");
    a_vpn_load: assert property (@(posedge pclk) disable iff (!presetn)      // see RL1
        exc_valid && exc_code == EXC_TLBL |=> vpn_field == $past(exc_vaddr[31:13]))
        else $error("page pair field not loaded");
    a_tick_rate: assert property (@(posedge pclk) disable iff (!presetn)     // see RL5
        presetn && !wr_acc ##1 !wr_acc ##1 1'b1 |-> tick == $past(tick, 2) + 1'b1)
        else $error("tick counter rate wrong");
    a_cmp_clear: assert property (@(posedge pclk) disable iff (!presetn)     // see RL7
        s_cmp_write and !(match_chk && tick == compare) |=> !timer_pend)
        else $error("compare write did not clear timer");
    a_timer_set: assert property (@(posedge pclk) disable iff (!presetn)     // see RL6
        match_chk && tick == compare |=> timer_pend)
        else $error("timer pending not set on match");
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)      // see RL9
        irq_take |-> status[ST_IE] && !status[ST_EXL] && !status[ST_ERL])
        else $error("interrupt taken while disabled");
    a_ie_delay: assert property (@(posedge pclk) disable iff (!presetn)      // see RL10
        $rose(status[ST_IE]) |-> !ie_eff [*3] ##1 (ie_eff || !status[ST_IE]))
        else $error("enable settle delay wrong");
    a_user_mode: assert property (@(posedge pclk) disable iff (!presetn)     // see RL13
        (status[ST_EXL] || status[ST_ERL] || privilege_mode_field == KSU_KERNEL) |-> kernel_mode && !user_mode && !super_mode)
        else $error("mode decode inconsistent");
endmodule

// ==== shared/cesr_pkg.sv ====
// Package with offsets, field positions, reset values and codes of the exception register set
package cesr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] REG_CONTEXT_IDX   = 8'h04;   // Page table pointer, index of own choosing
    localparam logic [7:0] REG_FAULTVA_IDX   = 8'h08;   // Faulting virtual address
    localparam logic [7:0] REG_TICK_IDX      = 8'h09;   // Tick counter
    localparam logic [7:0] REG_COMPARE_IDX   = 8'h0b;   // Timer compare
    localparam logic [7:0] REG_STATUS_IDX    = 8'h0c;   // Processor status
    localparam logic [7:0] REG_CAUSE_IDX     = 8'h0d;   // Exception cause
    localparam logic [7:0] REG_CONTEXT_HI    = 8'h14;   // Upper word of page table pointer
    localparam logic [7:0] REG_FAULTVA_HI    = 8'h18;   // Upper word of faulting address

    // Status field positions
    localparam int ST_IE   = 0;
    localparam int ST_EXL  = 1;
    localparam int ST_ERL  = 2;
    localparam int ST_KSU  = 3;    // Two bits, 4:3
    localparam int ST_UX   = 5;
    localparam int ST_SX   = 6;
    localparam int ST_KX   = 7;
    localparam int ST_IM   = 8;    // Eight bits, 15:8
    localparam int ST_DE   = 16;
    localparam int ST_CE   = 17;
    localparam int ST_CH   = 18;
    localparam int ST_SR   = 20;
    localparam int ST_BEV  = 22;
    localparam int ST_RE   = 25;
    localparam int ST_FR   = 26;
    localparam int ST_CU   = 28;   // Four bits, 31:28

    // Writable status bits; reserved bits read zero
    localparam logic [31:0] STATUS_WMASK = 32'hf657_ffff;
    localparam logic [31:0] STATUS_RESET = 32'h0040_0004;

    // Cause field positions
    localparam int CA_EXC  = 2;    // Five bits, 6:2
    localparam int CA_IP   = 8;    // Eight bits, 15:8
    localparam int CA_CE   = 28;   // Two bits, 29:28
    localparam int CA_BD   = 31;

    // Privilege field encodings
    localparam logic [1:0] KSU_KERNEL = 2'h0;
    localparam logic [1:0] KSU_SUPER  = 2'h1;
    localparam logic [1:0] KSU_USER   = 2'h2;

    // Exception cause codes
    localparam logic [4:0] EXC_INT  = 5'h00;
    localparam logic [4:0] EXC_MOD  = 5'h01;
    localparam logic [4:0] EXC_TLBL = 5'h02;
    localparam logic [4:0] EXC_TLBS = 5'h03;
    localparam logic [4:0] EXC_ADEL = 5'h04;
    localparam logic [4:0] EXC_ADES = 5'h05;
    localparam logic [4:0] EXC_IBE  = 5'h06;
    localparam logic [4:0] EXC_DBE  = 5'h07;
    localparam logic [4:0] EXC_SYS  = 5'h08;
    localparam logic [4:0] EXC_BP   = 5'h09;
    localparam logic [4:0] EXC_RI   = 5'h0a;
    localparam logic [4:0] EXC_CPU  = 5'h0b;
    localparam logic [4:0] EXC_OV   = 5'h0c;
    localparam logic [4:0] EXC_TR   = 5'h0d;
    localparam logic [4:0] EXC_FPE  = 5'h0f;
    localparam logic [4:0] EXC_VCEI = 5'h0e;   // Coherency codes, part of the fixed encoding recorded in cause
    localparam logic [4:0] EXC_VCED = 5'h1f;

    // Interrupt enable settle delay in cycles
    localparam int IE_DELAY = 3;
    // Tick divider: count advances every second cycle
    localparam int TICK_DIV = 2;

    // Page number field of pointer register
    localparam int VPN_LSB = 4;
    localparam int VPN_W   = 19;

endpackage

// ==== shared/cesr_exc_if.sv ====
// Interface carrying exception events from the recorder to the register core
`timescale 1ns/1ns
interface cesr_exc_if;
    logic        load_fva;    // Faulting address load strobe
    logic        load_vpn;    // Page pair field load strobe
    logic [63:0] vaddr;       // Captured virtual address
    modport rec  (output load_fva, output load_vpn, output vaddr);
    modport core (input  load_fva, input  load_vpn, input  vaddr);
endinterface

// ==== core/cesr_fault_rec.sv ====
// Decides which exceptions update the address capture registers
`timescale 1ns/1ns
module cesr_fault_rec
    import cesr_pkg::*;
(
    // Exception event in
    input  wire logic        exc_valid,
    input  wire logic [4:0]  exc_code,
    input  wire logic [63:0] exc_vaddr,
    input  wire logic        exl_now,
    // To register core
    cesr_exc_if.rec          ev
);
    logic addr_kind;   // Code is one of the address-reporting kinds

    // Address, translation and coherency faults report; bus errors do not
    always_comb begin
        case (exc_code)
            EXC_MOD, EXC_TLBL, EXC_TLBS,
            EXC_ADEL, EXC_ADES,
            EXC_VCEI, EXC_VCED: addr_kind = 1'b1;   // see RL2
            default:            addr_kind = 1'b0;   // see RL4
        endcase
    end

    // Fault address load held off while already at exception level
    assign ev.load_fva = exc_valid && addr_kind && !exl_now;                       // see RL3
    assign ev.load_vpn = exc_valid &&
                         (exc_code == EXC_TLBL || exc_code == EXC_TLBS || exc_code == EXC_MOD); // see RL1
    assign ev.vaddr    = exc_vaddr;
endmodule

// ==== verification/cesr_pipe_model.sv ====
// Pipeline-side model raising exception, return, soft reset and cache events
`timescale 1ns/1ns
module cesr_pipe_model (
    // Clock
    input  wire logic        pclk,
    // Event outputs to the register core
    output logic             exc_valid,
    output logic      [4:0]  exc_code,
    output logic      [63:0] exc_vaddr,
    output logic             exc_in_delay,
    output logic      [1:0]  exc_cop_unit,
    output logic             exc_return,
    output logic             soft_reset_evt,
    output logic             cache_hit_op,
    output logic             cache_hit_result
);
    // Quiet at time zero
    initial begin
        {exc_valid, exc_code, exc_vaddr, exc_in_delay, exc_cop_unit} = '0;
        {exc_return, soft_reset_evt, cache_hit_op, cache_hit_result} = '0;
    end
    // One-cycle exception; address inverted afterwards so stale values never match
    task automatic take(input logic [4:0] c, input logic [63:0] va, input logic d, input logic [1:0] u);
        @(posedge pclk);
        {exc_valid, exc_code, exc_vaddr, exc_in_delay, exc_cop_unit} <= {1'b1, c, va, d, u};
        @(posedge pclk);
        exc_valid <= 1'b0;
        exc_vaddr <= ~va;
    endtask
    // One-cycle pulse: return, soft reset or cache hit op
    task automatic pulse(input logic [2:0] which, input logic hit);
        @(posedge pclk);
        {exc_return, soft_reset_evt, cache_hit_op} <= which;
        cache_hit_result <= hit;
        @(posedge pclk);
        {exc_return, soft_reset_evt, cache_hit_op} <= 3'h0;
        cache_hit_result <= ~hit;
    endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the exception state register set
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb
    import cesr_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d0;
    logic [5:0]  ext_irq;
    logic [1:0]  cop_req_unit, addr_space, exc_cop_unit;
    logic        exc_valid, exc_in_delay, exc_return, soft_reset_evt, cache_hit_op, cache_hit_result;
    logic [4:0]  exc_code;
    logic [63:0] exc_vaddr;
    logic        irq_take, kernel_mode, super_mode, user_mode, addr64, xtlb_vector;
    logic        boot_vectors, big_endian_eff, cop_unusable, space_denied, big_endian_strap;
    logic [63:0] va1 = 64'h0123_4567_89ab_cdef;  // Address for fault captures
    int          errors = 0, samples_checked = 0, cycles = 0;

    cesr_core i_cesr_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .exc_valid, .exc_code, .exc_vaddr, .exc_in_delay, .exc_cop_unit, .exc_return,
        .soft_reset_evt, .cache_hit_op, .cache_hit_result, .big_endian_strap, .ext_irq, .cop_req_unit,
        .addr_space, .irq_take, .kernel_mode, .super_mode, .user_mode, .addr64, .xtlb_vector,
        .boot_vectors, .big_endian_eff, .cop_unusable, .space_denied);
    cesr_pipe_model i_cesr_pipe_model (.pclk, .exc_valid, .exc_code, .exc_vaddr, .exc_in_delay,
        .exc_cop_unit, .exc_return, .soft_reset_evt, .cache_hit_op, .cache_hit_result);

    // Clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Hang guard, far above the expected run length
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    // Counts, verdict, end of run
    task automatic report_and_stop();
        $display("TB: errors=%0d checks=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // APB transfer by register index; waits for pready, never assumes latency
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, 2'h0, idx, 2'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    // Reset state and an unmapped index
    task automatic s_reset();
        apb(0, REG_STATUS_IDX, 0);
        `CHK(rd, STATUS_RESET)
        `CHK(boot_vectors, 1'b1)
        apb(1, 8'h01, 32'h5a5a_5a5a);
        `CHK({err, rd}, 33'h1_0000_0000) // Refused
    endtask
    // Software pending bits, masking and the enable delay
    task automatic s_swirq();
        apb(1, REG_CAUSE_IDX, 32'hffff_ffff);
        apb(0, REG_CAUSE_IDX, 0);
        `CHK(rd, 32'h0000_0300)
        apb(1, REG_STATUS_IDX, 32'h0040_0101);
        @(negedge pclk);
        `CHK(irq_take, 1'b0)
        repeat (4) @(negedge pclk);
        `CHK(irq_take, 1'b1)
        apb(1, REG_CAUSE_IDX, 32'h0);
        ext_irq <= 6'h01;
        repeat (2) @(posedge pclk);
        apb(0, REG_CAUSE_IDX, 0);
        `CHK(rd[15:8], 8'h04)
        @(negedge pclk);
        `CHK(irq_take, 1'b0)
        apb(1, REG_STATUS_IDX, 32'h0040_0401);
        @(negedge pclk);
        `CHK(irq_take, 1'b1)
        ext_irq <= 6'h00;
    endtask
    // Tick rate, compare match and clear on compare write
    task automatic s_timer();
        apb(1, REG_STATUS_IDX, 32'h0040_8001);
        apb(0, REG_TICK_IDX, 0);
        d0 = rd;
        repeat (17) @(posedge pclk);
        apb(0, REG_TICK_IDX, 0);
        `CHK(rd - d0, 32'd10)
        apb(1, REG_TICK_IDX, 32'h0);
        apb(1, REG_COMPARE_IDX, 32'd40);
        apb(0, REG_CAUSE_IDX, 0);
        `CHK(rd[15], 1'b0)
        for (int n = 0; n < 60 && rd[15] !== 1'b1; n++) apb(0, REG_CAUSE_IDX, 0);
        `CHK(rd[15], 1'b1)
        repeat (4) @(negedge pclk);
        `CHK(irq_take, 1'b1)
        apb(0, REG_COMPARE_IDX, 0);
        `CHK(rd, 32'd40)
        apb(1, REG_COMPARE_IDX, 32'hffff_ffff);
        apb(0, REG_CAUSE_IDX, 0);
        `CHK(rd[15], 1'b0)
    endtask
    // Mode decode table: status, {space, unit}, expected mode outputs
    task automatic s_modes();
        logic [31:0] st [4] = '{32'h0240_0030, 32'h2240_0048, 32'h0040_0080, 32'h0000_0012};
        logic [3:0]  q [4]  = '{4'b1000, 4'b1001, 4'b1000, 4'b1111};
        logic [8:0]  ex [4] = '{9'b100101111, 9'b010101001, 9'b001111000, 9'b001100010};
        for (int i = 0; i < 4; i++) begin
            apb(1, REG_STATUS_IDX, st[i]);
            {addr_space, cop_req_unit} <= q[i];
            @(negedge pclk);
            `CHK({user_mode, super_mode, kernel_mode, addr64, xtlb_vector, boot_vectors, big_endian_eff,
                cop_unusable, space_denied}, ex[i])
        end
    endtask
    // Fault address, page pair field and cause fields
    task automatic s_events();
        apb(1, REG_STATUS_IDX, 32'h0040_0000);
        i_cesr_pipe_model.take(EXC_TLBL, va1, 1'b0, 2'h0);
        apb(0, REG_FAULTVA_IDX, 0);
        `CHK(rd, va1[31:0])
        apb(0, REG_FAULTVA_HI, 0);
        `CHK(rd, va1[63:32])
        apb(0, REG_CONTEXT_IDX, 0);
        `CHK(rd, {9'h0, va1[31:13], 4'h0})
        i_cesr_pipe_model.take(EXC_ADEL, ~va1, 1'b0, 2'h0);
        apb(0, REG_FAULTVA_IDX, 0);
        `CHK(rd, va1[31:0])
        i_cesr_pipe_model.pulse(3'b100, 1'b0);
        i_cesr_pipe_model.take(EXC_DBE, ~va1, 1'b0, 2'h0);
        apb(0, REG_FAULTVA_IDX, 0);
        `CHK(rd, va1[31:0])
        i_cesr_pipe_model.pulse(3'b100, 1'b0);
        i_cesr_pipe_model.take(EXC_ADES, ~va1, 1'b0, 2'h0);
        apb(0, REG_FAULTVA_IDX, 0);
        `CHK(rd, ~va1[31:0])
        i_cesr_pipe_model.take(EXC_CPU, va1, 1'b1, 2'h2);
        apb(0, REG_CAUSE_IDX, 0);
        `CHK({rd[31], rd[29:28], rd[6:2]}, {3'b110, EXC_CPU})
        for (int c = 0; c < 16; c++) if (c != 14) begin
            i_cesr_pipe_model.take(c[4:0], va1, 1'b0, 2'h0);
            apb(0, REG_CAUSE_IDX, 0);
            `CHK(rd[6:2], c[4:0])
        end
    endtask
    // Soft reset flag and cache hit flag
    task automatic s_flags();
        i_cesr_pipe_model.pulse(3'b010, 1'b0);
        apb(0, REG_STATUS_IDX, 0);
        `CHK({rd[ST_SR], rd[ST_ERL]}, 2'b11)
        for (int h = 1; h >= 0; h--) begin
            i_cesr_pipe_model.pulse(3'b001, h[0]);
            apb(0, REG_STATUS_IDX, 0);
            `CHK(rd[ST_CH], h[0])
        end
    endtask
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ext_irq, cop_req_unit, addr_space} = '0;
        big_endian_strap = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_swirq();
        s_timer();
        s_modes();
        s_events();
        s_flags();
        report_and_stop();
    end
endmodule
